// File: pkg/eab_pkg.sv
package eab_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Product-term array geometry.
   localparam int EAB_NUM_IN = 32;
   localparam int EAB_NUM_FB = 9;
   localparam int EAB_NUM_LINE = 41;
   localparam int EAB_NUM_MC = 16;
   localparam int EAB_NUM_PT = 32;
   localparam int EAB_NUM_LOCAL_OUT = 10;

   // Macrocell register types.
   localparam logic [1:0] EAB_RT_D = 2'h0;
   localparam logic [1:0] EAB_RT_T = 2'h1;
   localparam logic [1:0] EAB_RT_JK = 2'h2;
   localparam logic [1:0] EAB_RT_SR = 2'h3;

   // Macrocell clear selection.
   localparam logic [1:0] EAB_CLR_NONE = 2'h0;
   localparam logic [1:0] EAB_CLR_A = 2'h1;
   localparam logic [1:0] EAB_CLR_B = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Memory geometry and shapes.
   localparam int EAB_MEM_ROWS = 128;
   localparam int EAB_MEM_WIDTH = 16;
   localparam int EAB_ADDR_BITS = 11;
   localparam int EAB_ROW_BITS = 7;
   localparam logic [2:0] EAB_SHAPE_128X16 = 3'h0;
   localparam logic [2:0] EAB_SHAPE_256X8 = 3'h1;
   localparam logic [2:0] EAB_SHAPE_512X4 = 3'h2;
   localparam logic [2:0] EAB_SHAPE_1024X2 = 3'h3;
   localparam logic [2:0] EAB_SHAPE_2048X1 = 3'h4;

   // Dual-port clocking schemes.
   localparam logic EAB_MODE_RW_CLK = 1'b0;
   localparam logic EAB_MODE_IO_CLK = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0] reg_type;
      logic bypass;
      logic invert_b;
      logic xor_pol;
      logic clk_sel;
      logic [1:0] clr_sel;
      logic lend;
   } eab_mc_cfg_s;

   typedef struct packed {
      logic [EAB_NUM_LINE-1:0] use_true;
      logic [EAB_NUM_LINE-1:0] use_comp;
   } eab_pt_cfg_s;

   typedef struct packed {
      logic write_strobe;
      logic read_strobe;
      logic [EAB_ADDR_BITS-1:0] write_addr;
      logic [EAB_ADDR_BITS-1:0] read_addr;
      logic [EAB_MEM_WIDTH-1:0] write_data;
   } eab_mem_req_s;

   typedef struct packed {
      logic clk_mode;
      logic [2:0] shape;
      logic out_pipe;
      logic deep_en;
   } eab_mem_cfg_s;

endpackage : eab_pkg

// File: rtl/eab_embedded_array_block.sv
`timescale 1ns/10ps
// Behaviour
// R1 - Sixteen macrocells, two product terms, one register.
// R2 - Thirty-two inputs; nine macrocell outputs fed back.
// R3 - Register acts as D, T, JK, SR or bypassed.
// R4 - Second product term optionally inverted before sum.
// R5 - Register uses selected block clock and its enable.
// R6 - Each block clock net has its own edge polarity.
// R7 - Two invertible clears; macrocell picks one or none.
// R8 - Idle terms lent onward, chain reaching thirty-two terms.
// R9 - Input registers capture writes; optional output pipeline.
// R10 - Write strobe generated internally, one cycle after capture.
// R11 - Five memory shapes from 128x16 to 2048x1.
// R12 - Ten local outputs carry nine distinct signals.
// R13 - Page decoder on upper bits enables tri-state driver.
// R14 - Tri-state driver on only for the matched page.
// R15 - Simultaneous read and write on two clocks.
// R16 - One write port, one read port per block.
// R17 - Read/write mode: write clock and read clock sides.
// R18 - Read/write mode: independent enables and clears per side.
// R19 - Input/output mode: inputs on one clock, output other.
// R20 - Input/output mode: independent enables and clears per side.
// R21 - Memory registers clearable locally, globally or chip-wide.
// R22 - Chip-wide clear overrides every other control.
// R23 - Asserted clear forces register zero and holds.
module eab_embedded_array_block
   import eab_pkg::*;
#(
   parameter int PAGE_BITS = 2
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_device_global_clear_n,
   input wire logic [1:0] i_blk_clock,
   input wire logic [1:0] i_blk_clock_fall,
   input wire logic [1:0] i_blk_ce,
   input wire logic [1:0] i_clear_src,
   input wire logic [1:0] i_clear_inv,
   input wire logic i_global_clear,
   input wire logic i_mode_memory,
   input wire logic [EAB_NUM_IN-1:0] i_local_in,
   input wire eab_pt_cfg_s [EAB_NUM_PT-1:0] i_pt_cfg,
   input wire eab_mc_cfg_s [EAB_NUM_MC-1:0] i_mc_cfg,
   input wire eab_mem_cfg_s i_mem_cfg,
   input wire eab_mem_req_s i_mem_req,
   input wire logic [1:0] i_mem_clr,
   input wire logic [PAGE_BITS-1:0] i_page_addr,
   input wire logic [PAGE_BITS-1:0] i_page_id,
   output logic [EAB_NUM_MC-1:0] o_mc_out,
   output logic [EAB_NUM_LOCAL_OUT-1:0] o_local_out,
   output logic [EAB_MEM_WIDTH-1:0] o_mem_data,
   output logic [EAB_MEM_WIDTH-1:0] o_tri_data,
   output logic o_tri_oe
);

   if (PAGE_BITS < 1 || PAGE_BITS > 8) begin : g_bad_page
      $error("PAGE_BITS must lie between 1 and 8.");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Functions.
   function automatic logic f_pterm(input logic [EAB_NUM_LINE-1:0] lines,
                                    input eab_pt_cfg_s cfg);
      return &((~cfg.use_true | lines) & (~cfg.use_comp | ~lines));
   endfunction : f_pterm

   function automatic logic f_next(input logic [1:0] rt, input logic q,
                                   input logic s, input logic r);
      logic n;
      n = q;
      unique case (rt)
         EAB_RT_D: n = s;
         EAB_RT_T: n = q ^ s;
         EAB_RT_JK: n = (s & r) ? ~q : (s ? 1'b1 : (r ? 1'b0 : q));
         EAB_RT_SR: n = s ? 1'b1 : (r ? 1'b0 : q);
      endcase
      return n;
   endfunction : f_next

   function automatic logic [EAB_ROW_BITS-1:0] f_row(input logic [EAB_ADDR_BITS-1:0] a,
                                                     input logic [2:0] shp);
      logic [EAB_ADDR_BITS-1:0] t;
      t = a >> shp;
      return t[EAB_ROW_BITS-1:0];
   endfunction : f_row

   function automatic int f_sel(input logic [EAB_ADDR_BITS-1:0] a, input logic [2:0] shp);
      return int'(a) & ((1 << shp) - 1);
   endfunction : f_sel

   function automatic logic [EAB_MEM_WIDTH-1:0] f_wmask(input logic [EAB_ADDR_BITS-1:0] a,
                                                        input logic [2:0] shp);
      logic [EAB_MEM_WIDTH-1:0] m;
      m = '0;
      for (int b = 0; b < EAB_MEM_WIDTH; b++) begin
         m[b] = ((b >> (4 - shp)) == f_sel(a, shp));
      end
      return m;
   endfunction : f_wmask

   function automatic logic [EAB_MEM_WIDTH-1:0] f_spread(input logic [EAB_MEM_WIDTH-1:0] d,
                                                         input logic [2:0] shp);
      logic [EAB_MEM_WIDTH-1:0] m;
      m = '0;
      for (int b = 0; b < EAB_MEM_WIDTH; b++) begin
         m[b] = d[b & ((EAB_MEM_WIDTH >> shp) - 1)];
      end
      return m;
   endfunction : f_spread

   function automatic logic [EAB_MEM_WIDTH-1:0] f_rsel(input logic [EAB_MEM_WIDTH-1:0] w,
                                                       input logic [EAB_ADDR_BITS-1:0] a,
                                                       input logic [2:0] shp);
      logic [EAB_MEM_WIDTH-1:0] r;
      int wid;
      int idx;
      r = '0;
      wid = EAB_MEM_WIDTH >> shp;
      for (int i = 0; i < EAB_MEM_WIDTH; i++) begin
         idx = f_sel(a, shp) * wid + i;
         if (i < wid && idx < EAB_MEM_WIDTH) begin
            r[i] = w[idx];
         end
      end
      return r;
   endfunction : f_rsel

   ////////////////////////////////////////////////////////////////////////////
   // Block clock pins: three-stage synchroniser and filtered edges.
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] sync3_q;
   logic [1:0] lvl_q;
   logic [1:0] lvl_d;
   logic [1:0] settled;
   logic [1:0] rise;
   logic [1:0] fall;
   logic [1:0] blk_edge;
   logic [1:0] blk_tick;
   logic hard_clr;

   assign hard_clr = i_sys_rst | ~i_device_global_clear_n; // R22
   // The level moves only once stages two and three agree, so a pin glitch shorter than a
   // cycle never turns into a block clock edge.
   assign settled = ~(sync2_q ^ sync3_q);
   assign lvl_d = (settled & sync2_q) | (~settled & lvl_q);
   assign rise = settled & sync2_q & ~lvl_q;
   assign fall = settled & ~sync2_q & lvl_q;
   assign blk_edge = (i_blk_clock_fall & fall) | (~i_blk_clock_fall & rise); // R6
   assign blk_tick = blk_edge & i_blk_ce;

   always_ff @(posedge i_clock) begin
      if (hard_clr) begin
         sync1_q <= '0;
         sync2_q <= '0;
         sync3_q <= '0;
         lvl_q <= '0;
      end else begin
         sync1_q <= i_blk_clock;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         lvl_q <= lvl_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Product-term macrocells.
   logic [EAB_NUM_MC-1:0] mc_q;
   logic [EAB_NUM_MC-1:0] mc_d;
   logic [EAB_NUM_MC-1:0] own_sum;
   logic [EAB_NUM_MC-1:0] exp_in;
   logic [EAB_NUM_MC-1:0] exp_out;
   logic [EAB_NUM_MC-1:0] logic_out;
   logic [EAB_NUM_MC-1:0] mc_tick;
   logic [EAB_NUM_MC-1:0] mc_clr;
   logic [EAB_NUM_MC-1:0] pt_b;
   logic [1:0] clr_line;
   logic [EAB_NUM_LINE-1:0] lines;

   assign lines = {mc_q[EAB_NUM_FB-1:0], i_local_in}; // R2
   assign clr_line = i_clear_src ^ i_clear_inv; // R7

   for (genvar m = 0; m < EAB_NUM_MC; m++) begin : g_mc // R1
      logic pt_a;
      assign pt_a = f_pterm(lines, i_pt_cfg[2*m]);
      assign pt_b[m] = f_pterm(lines, i_pt_cfg[2*m+1]);
      assign own_sum[m] = pt_a | (pt_b[m] ^ i_mc_cfg[m].invert_b); // R4
      assign exp_out[m] = own_sum[m] | exp_in[m]; // R8
      if (m == EAB_NUM_MC - 1) begin : g_last
         assign exp_in[m] = 1'b0;
      end else begin : g_chain
         assign exp_in[m] = i_mc_cfg[m+1].lend & exp_out[m+1]; // R8
      end
      assign logic_out[m] = (~i_mc_cfg[m].lend & exp_out[m]) ^ i_mc_cfg[m].xor_pol;
      assign mc_tick[m] = blk_tick[i_mc_cfg[m].clk_sel]; // R5
      assign mc_clr[m] = (i_mc_cfg[m].clr_sel == EAB_CLR_A & clr_line[0])
                       | (i_mc_cfg[m].clr_sel == EAB_CLR_B & clr_line[1]); // R7
      assign mc_d[m] = (mc_clr[m] | i_mode_memory) ? 1'b0 : // R23
                       i_mc_cfg[m].bypass ? logic_out[m] : // R3
                       mc_tick[m] ? f_next(i_mc_cfg[m].reg_type, mc_q[m], logic_out[m],
                                           pt_b[m]) : mc_q[m]; // R3

      a_mc_clear_zero: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R23
         mc_clr[m] |=> !mc_q[m]) else $error("Cleared macrocell not zero.");
      a_mc_gate_hold: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R5
         (!mc_tick[m] && !mc_clr[m] && !i_mc_cfg[m].bypass && !i_mode_memory
          && i_device_global_clear_n) |=> $stable(mc_q[m]))
         else $error("Macrocell changed without clock and enable.");
      a_mc_d_capture: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R3
         (mc_tick[m] && !mc_clr[m] && !i_mc_cfg[m].bypass && !i_mode_memory
          && i_mc_cfg[m].reg_type == EAB_RT_D && i_device_global_clear_n)
         |=> mc_q[m] == $past(logic_out[m])) else $error("D macrocell missed its sum.");
      a_mc_lend_quiet: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R8
         (i_mc_cfg[m].lend && !mc_clr[m] && !i_mode_memory && i_device_global_clear_n
          && (i_mc_cfg[m].bypass || (mc_tick[m] && i_mc_cfg[m].reg_type == EAB_RT_D)))
         |=> mc_q[m] == $past(i_mc_cfg[m].xor_pol))
         else $error("Lending macrocell showed more than its polarity.");
   end

   always_ff @(posedge i_clock) begin
      if (hard_clr) begin
         mc_q <= '0; // R22
      end else begin
         mc_q <= mc_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Memory side strobes and clears.
   logic [2:0] shape;
   logic wr_tick;
   logic out_tick;
   logic rd_tick;
   logic in_clr;
   logic out_clr;
   logic rd_clr;
   logic io_mode;

   assign shape = (i_mem_cfg.shape > EAB_SHAPE_2048X1) ? EAB_SHAPE_2048X1 : i_mem_cfg.shape; // R11
   assign io_mode = i_mem_cfg.clk_mode == EAB_MODE_IO_CLK;
   assign wr_tick = blk_tick[0] & i_mode_memory; // R15
   assign out_tick = blk_tick[1] & i_mode_memory;
   assign rd_tick = io_mode ? wr_tick : out_tick; // R17 R19
   assign in_clr = i_mem_clr[0] | i_global_clear; // R21
   assign out_clr = i_mem_clr[1] | i_global_clear; // R21
   assign rd_clr = io_mode ? in_clr : out_clr; // R18 R20

   ////////////////////////////////////////////////////////////////////////////
   // Memory registers and array: one write port and one read port.
   logic [EAB_MEM_WIDTH-1:0] mem_q [EAB_MEM_ROWS]; // R16
   logic wr_strobe_q;
   logic [EAB_ADDR_BITS-1:0] waddr_q;
   logic [EAB_MEM_WIDTH-1:0] wdata_q;
   logic wpend_q;
   logic wpend_d;
   logic rd_strobe_q;
   logic [EAB_ADDR_BITS-1:0] raddr_q;
   logic [PAGE_BITS-1:0] rpage_q;
   logic [EAB_MEM_WIDTH-1:0] rdata_q;
   logic [EAB_MEM_WIDTH-1:0] rdata_d;
   logic [EAB_MEM_WIDTH-1:0] pipe_q;
   logic [EAB_MEM_WIDTH-1:0] mem_out_d;
   logic [EAB_MEM_WIDTH-1:0] wmask;
   logic [EAB_MEM_WIDTH-1:0] wspread;
   logic [EAB_ROW_BITS-1:0] wrow;
   logic page_hit;
   logic tri_oe_d;

   assign wpend_d = wr_tick & ~in_clr & i_mem_req.write_strobe; // R10
   assign wrow = f_row(waddr_q, shape);
   assign wmask = f_wmask(waddr_q, shape); // R11
   assign wspread = f_spread(wdata_q, shape);
   assign rdata_d = rd_clr ? '0 :
                    rd_strobe_q ? f_rsel(mem_q[f_row(raddr_q, shape)], raddr_q, shape) :
                    rdata_q;
   assign mem_out_d = out_clr ? '0 : (i_mem_cfg.out_pipe ? pipe_q : rdata_q); // R9
   assign page_hit = rpage_q == i_page_id; // R13
   assign tri_oe_d = i_mode_memory & i_mem_cfg.deep_en & page_hit; // R14

   always_ff @(posedge i_clock) begin
      if (wpend_q) begin
         mem_q[wrow] <= (mem_q[wrow] & ~wmask) | (wspread & wmask); // R10
      end
   end

   always_ff @(posedge i_clock) begin
      if (hard_clr || in_clr) begin
         wr_strobe_q <= 1'b0; // R21 R23
         waddr_q <= '0;
         wdata_q <= '0;
      end else if (wr_tick) begin
         wr_strobe_q <= i_mem_req.write_strobe; // R9 R17
         waddr_q <= i_mem_req.write_addr;
         wdata_q <= i_mem_req.write_data;
      end
   end

   always_ff @(posedge i_clock) begin
      if (hard_clr || rd_clr) begin
         rd_strobe_q <= 1'b0; // R18 R20
         raddr_q <= '0;
         rpage_q <= '0;
      end else if (rd_tick) begin
         rd_strobe_q <= i_mem_req.read_strobe; // R17 R19
         raddr_q <= i_mem_req.read_addr;
         rpage_q <= i_page_addr;
      end
   end

   always_ff @(posedge i_clock) begin
      if (hard_clr || out_clr) begin
         pipe_q <= '0; // R20
      end else if (out_tick) begin
         pipe_q <= rdata_q; // R9
      end
   end

   always_ff @(posedge i_clock) begin
      if (hard_clr) begin
         wpend_q <= 1'b0;
         rdata_q <= '0;
         o_mem_data <= '0;
         o_tri_data <= '0;
         o_tri_oe <= 1'b0;
         o_mc_out <= '0;
         o_local_out <= '0;
      end else begin
         wpend_q <= wpend_d;
         rdata_q <= rdata_d;
         o_mem_data <= mem_out_d;
         o_tri_data <= tri_oe_d ? mem_out_d : '0; // R13
         o_tri_oe <= tri_oe_d; // R14
         o_mc_out <= mc_d;
         o_local_out <= i_mode_memory ? {mem_out_d[8], mem_out_d[8:0]} :
                        {mc_d[8], mc_d[8:0]}; // R12
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   a_dev_clear_all: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R22
      !i_device_global_clear_n |=> (mc_q == '0 && o_mem_data == '0 && !o_tri_oe
      && !wpend_q && pipe_q == '0)) else $error("Chip clear did not clear block.");
   a_write_self_timed: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R10
      (wr_tick && !in_clr && i_mem_req.write_strobe && i_device_global_clear_n)
      |=> wpend_q && waddr_q == $past(i_mem_req.write_addr))
      else $error("Write not captured and strobed.");
   a_read_side_clear: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R18
      out_clr |=> (o_mem_data == '0 && pipe_q == '0))
      else $error("Output clear did not zero output.");
   a_pipe_latency: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R9
      (out_tick && !out_clr && i_device_global_clear_n) ##1
      (i_mem_cfg.out_pipe && !out_clr && i_device_global_clear_n)
      |=> o_mem_data == $past(rdata_q, 2)) else $error("Pipelined data late.");
   a_tri_owner: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R14
      o_tri_oe |-> ($past(i_mem_cfg.deep_en) && $past(i_mode_memory)
                    && $past(rpage_q) == $past(i_page_id)))
      else $error("Driver on for unselected page.");
   a_tri_data_gate: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R13
      o_tri_data == (o_tri_oe ? o_mem_data : '0))
      else $error("Tri-state data differs from gated output.");
   a_local_dup: assert property (@(posedge i_clock) disable iff (i_sys_rst) // R12
      o_local_out == ($past(i_mode_memory) ? {o_mem_data[8], o_mem_data[8:0]}
                                           : {o_mc_out[8], o_mc_out[8:0]}))
      else $error("Local outputs do not follow the block state.");

   c_write_then_read: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      wpend_q ##[1:20] (rd_strobe_q && raddr_q == waddr_q));
   c_tri_drive: cover property (@(posedge i_clock) disable iff (i_sys_rst) o_tri_oe);
   c_mc_toggle: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      mc_tick[0] && i_mc_cfg[0].reg_type == EAB_RT_T && logic_out[0]);
   c_pipe_read: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      out_tick && i_mem_cfg.out_pipe && rd_strobe_q);
   c_lend_chain: cover property (@(posedge i_clock) disable iff (i_sys_rst)
      mc_tick[4] && exp_in[4] && !own_sum[4]);

endmodule : eab_embedded_array_block

// File: tb/eab_embedded_array_block_tb.sv
`timescale 1ns/10ps
module eab_embedded_array_block_tb;
   import eab_pkg::*;
   logic i_clock = 1'h0;
   logic i_sys_rst = 1'h1;
   logic i_device_global_clear_n = 1'h1;
   logic i_global_clear = 1'h0;
   logic i_mode_memory = 1'h0;
   logic [1:0] i_blk_clock, i_blk_clock_fall, i_blk_ce, i_clear_src, i_clear_inv, i_mem_clr;
   logic [31:0] i_local_in;
   eab_pt_cfg_s [31:0] i_pt_cfg;
   eab_mc_cfg_s [15:0] i_mc_cfg;
   eab_mem_cfg_s i_mem_cfg;
   eab_mem_req_s i_mem_req;
   logic [1:0] i_page_addr, i_page_id;
   logic [15:0] o_mc_out, o_mem_data, o_tri_data, d;
   logic [9:0] o_local_out;
   logic o_tri_oe;
   logic [16:0] mask;
   logic [10:0] a;
   int mismatches = 0;
   int samples_checked = 0;

   always #20 i_clock = ~i_clock;

   eab_fabric_model fab (.i_clock(i_clock), .o_blk_clock(i_blk_clock));

   eab_embedded_array_block #(.PAGE_BITS(2)) uut (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst),
      .i_device_global_clear_n(i_device_global_clear_n), .i_blk_clock(i_blk_clock),
      .i_blk_clock_fall(i_blk_clock_fall), .i_blk_ce(i_blk_ce), .i_clear_src(i_clear_src),
      .i_clear_inv(i_clear_inv), .i_global_clear(i_global_clear),
      .i_mode_memory(i_mode_memory), .i_local_in(i_local_in), .i_pt_cfg(i_pt_cfg),
      .i_mc_cfg(i_mc_cfg), .i_mem_cfg(i_mem_cfg), .i_mem_req(i_mem_req),
      .i_mem_clr(i_mem_clr), .i_page_addr(i_page_addr), .i_page_id(i_page_id),
      .o_mc_out(o_mc_out), .o_local_out(o_local_out), .o_mem_data(o_mem_data),
      .o_tri_data(o_tri_data), .o_tri_oe(o_tri_oe)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("Comparisons: %0d, mismatches: %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   // Each call returns at a falling edge so that outputs are settled when read.
   task automatic tick(input int k);
      fab.pulse(k);
      @(negedge i_clock);
   endtask : tick

   task automatic mem_write(input logic [10:0] wa, input logic [15:0] wd);
      @(posedge i_clock);
      i_mem_req.write_strobe <= 1'h1;
      i_mem_req.write_addr <= wa;
      i_mem_req.write_data <= wd;
      fab.pulse(0);
      i_mem_req.write_strobe <= 1'h0;
      @(negedge i_clock);
   endtask : mem_write

   task automatic mem_read(input logic [10:0] ra, input logic [1:0] pg, input int k);
      @(posedge i_clock);
      i_mem_req.read_strobe <= 1'h1;
      i_mem_req.read_addr <= ra;
      i_page_addr <= pg;
      fab.pulse(k);
      i_mem_req.read_strobe <= 1'h0;
      @(negedge i_clock);
   endtask : mem_read

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(40 * 4000);
      mismatches++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      print_verdict();
   end

   initial begin
      i_blk_clock_fall = 2'h2;
      i_blk_ce = 2'h3;
      i_clear_src = 2'h0;
      i_clear_inv = 2'h0;
      i_mem_clr = 2'h0;
      i_local_in = 32'h0000_0003;
      i_mem_cfg = '{1'h0, 3'h0, 1'h0, 1'h1};
      i_mem_req = '0;
      i_page_addr = 2'h0;
      i_page_id = 2'h2;
      i_pt_cfg = '0;
      // Odd terms and term 4 are constant zero: one line ANDed with its complement.
      for (int i = 1; i < 32; i += 2) begin
         i_pt_cfg[i].use_true[40] = 1'h1;
         i_pt_cfg[i].use_comp[40] = 1'h1;
      end
      i_pt_cfg[4] = i_pt_cfg[1];
      i_pt_cfg[0].use_true[0] = 1'h1;
      i_pt_cfg[2].use_true[1] = 1'h1;
      i_pt_cfg[8].use_true[32] = 1'h1;
      i_mc_cfg = '0;
      i_mc_cfg[0].clr_sel = EAB_CLR_A;
      i_mc_cfg[1].reg_type = EAB_RT_T;
      i_mc_cfg[1].clk_sel = 1'h1;
      i_mc_cfg[2].bypass = 1'h1;
      i_mc_cfg[2].invert_b = 1'h1;
      repeat (8) @(posedge i_clock);
      i_sys_rst <= 1'h0;
      @(negedge i_clock);
      check(o_mc_out, 16'h0);
      check(16'(o_tri_oe), 16'h0);
      tick(0);
      check(16'(o_mc_out[0]), 16'h1);
      check(16'(o_mc_out[4]), 16'h0);
      check(16'(o_local_out[0]), 16'h1);
      check(16'(o_mc_out[2]), 16'h1);
      check(o_mc_out, 16'hFFED);
      tick(0);
      check(16'(o_mc_out[4]), 16'h1);
      @(posedge i_clock) i_blk_ce[0] <= 1'h0;
      i_local_in[0] <= 1'h0;
      tick(0);
      check(16'(o_mc_out[0]), 16'h1);
      @(posedge i_clock) i_blk_ce[0] <= 1'h1;
      tick(0);
      check(16'(o_mc_out[0]), 16'h0);
      @(posedge i_clock);
      fab.set_pin(1, 1'h1);
      @(negedge i_clock);
      check(16'(o_mc_out[1]), 16'h0);
      @(posedge i_clock);
      fab.set_pin(1, 1'h0);
      @(negedge i_clock);
      check(16'(o_mc_out[1]), 16'h1);
      tick(1);
      check(16'(o_mc_out[1]), 16'h0);
      @(posedge i_clock) i_mc_cfg[2].invert_b <= 1'h0;
      i_local_in[0] <= 1'h1;
      tick(0);
      check(16'(o_mc_out[2]), 16'h0);
      check(16'(o_mc_out[0]), 16'h1);
      @(posedge i_clock) i_clear_inv <= 2'h1;
      repeat (3) @(negedge i_clock);
      check(16'(o_mc_out[0]), 16'h0);
      tick(0);
      check(16'(o_mc_out[0]), 16'h0);
      @(posedge i_clock) i_mc_cfg[5].lend <= 1'h1;
      tick(0);
      check(16'(o_mc_out[4]), 16'h1);
      check(16'(o_mc_out[5]), 16'h0);
      @(posedge i_clock) i_clear_inv <= 2'h0;
      tick(0);
      @(posedge i_clock) i_device_global_clear_n <= 1'h0;
      tick(0);
      check(o_mc_out, 16'h0);
      @(posedge i_clock) i_device_global_clear_n <= 1'h1;
      i_mode_memory <= 1'h1;
      i_blk_clock_fall <= 2'h0;
      for (int s = 0; s < 5; s++) begin
         @(posedge i_clock) i_mem_cfg.shape <= 3'(s);
         a = 11'(s * 300 + 5);
         d = 16'h9E35 ^ 16'(s);
         mask = (17'h1 << (16 >> s)) - 17'h1;
         mem_write(a, d);
         mem_read(a, 2'h2, 1);
         check(o_mem_data, d & mask[15:0]);
         check(16'(o_tri_oe), 16'h1);
         check(o_tri_data, d & mask[15:0]);
      end
      mem_read(a, 2'h1, 1);
      check(16'(o_tri_oe), 16'h0);
      check(o_tri_data, 16'h0);
      @(posedge i_clock) i_mem_cfg <= '{1'h0, 3'h0, 1'h1, 1'h1};
      mem_write(11'h07F, 16'h5AF0);
      mem_read(11'h07F, 2'h2, 1);
      check(16'(o_mem_data === 16'h5AF0), 16'h0);
      mem_read(11'h07F, 2'h2, 1);
      check(o_mem_data, 16'h5AF0);
      @(posedge i_clock) i_mem_cfg <= '{1'h1, 3'h0, 1'h0, 1'h1};
      mem_write(11'h011, 16'h3C3C);
      mem_read(11'h011, 2'h2, 0);
      check(o_mem_data, 16'h3C3C);
      @(posedge i_clock) i_mem_cfg.clk_mode <= 1'h0;
      mem_read(11'h07F, 2'h2, 0);
      check(o_mem_data, 16'h3C3C);
      @(posedge i_clock) i_mem_clr <= 2'h2;
      repeat (3) @(negedge i_clock);
      check(o_mem_data, 16'h0);
      @(posedge i_clock) i_mem_clr <= 2'h0;
      mem_read(11'h011, 2'h2, 1);
      check(o_mem_data, 16'h3C3C);
      @(posedge i_clock) i_global_clear <= 1'h1;
      repeat (3) @(negedge i_clock);
      check(o_mem_data, 16'h0);
      print_verdict();
   end
endmodule : eab_embedded_array_block_tb

// File: tb/eab_fabric_model.sv
`timescale 1ns/10ps
module eab_fabric_model (
   input wire logic i_clock,
   output logic [1:0] o_blk_clock
);
   initial begin
      o_blk_clock = 2'h0;
   end

   // Holds a block clock pin at one level long enough for the pin filter to see it.
   task set_pin(input int k, input logic v);
      o_blk_clock[k] <= v;
      repeat (6) @(posedge i_clock);
   endtask : set_pin

   // Drives one whole period of a block clock pin; the pin rests low outside a pulse.
   task pulse(input int k);
      @(posedge i_clock);
      set_pin(k, 1'h1);
      set_pin(k, 1'h0);
   endtask : pulse
endmodule : eab_fabric_model
